/* File: hdl/upt_cfg.svh */
`ifndef UPT_CFG_SVH
`define UPT_CFG_SVH
// sample clock rate and half of it, in Hz
`define UPT_CLK_HZ       28'h5f5e100
`define UPT_HALF_HZ      28'h2faf080
// bit rate limits and default, bits per second
`define UPT_BAUD_MIN     28'h0000064
`define UPT_BAUD_MAX     28'h4a7b620
`define UPT_BAUD_RST     28'h001c200
// register offsets
`define UPT_A_LINE       8'h00
`define UPT_A_DPOL       8'h04
`define UPT_A_BAUD       8'h08
`define UPT_A_IDLE       8'h0c
`define UPT_A_TRIG       8'h10
`define UPT_A_NTH        8'h14
`define UPT_A_PATV       8'h18
`define UPT_A_PATC       8'h1c
`define UPT_A_STAT       8'h20
// line configuration fields
`define UPT_F_POL        0
`define UPT_F_SIZE       4:1
`define UPT_F_PAR        6:5
`define UPT_F_STOP       8:7
`define UPT_F_TXEN       9
`define UPT_F_SRC        10
// trigger configuration fields
`define UPT_F_MODE       2:0
`define UPT_F_PLEN       5:4
`define UPT_F_SKIP       27:16
`define UPT_F_NTH        11:0
// reset values, symbol size limits and break wait in bit times
`define UPT_SIZE_RST     4'h8
`define UPT_SIZE_MIN     4'h5
`define UPT_SIZE_MAX     4'h9
`define UPT_IDLE_RST     32'h00000364
`define UPT_NTH_RST      12'h001
`define UPT_PATV_RST     32'h00000001
`define UPT_PATC_RST     32'h000000ff
`define UPT_BRK_BITS     2'h2
`endif

/* File: hdl/upt_pkg.sv */
package upt_pkg;
  typedef enum logic [2:0] {
    MODE_BURST, MODE_START, MODE_INDEXED, MODE_SYMBOL,
    MODE_PATTERN, MODE_PARITY, MODE_FRAMING, MODE_BREAK
  } upt_mode_t;
  typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} upt_parity_t;
  typedef enum logic [1:0] {STOP_ONE, STOP_ONE_HALF, STOP_TWO} upt_stop_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP1, ST_STOP2, ST_WAITHI
  } upt_dec_state_t;
  typedef struct packed {
    logic start_err;
    logic stop_err;
    logic parity_err;
    logic brk;
  } upt_flags_t;
  typedef struct packed {
    logic [8:0] data;
    upt_flags_t flags;
  } upt_sym_t;
  typedef struct packed {
    logic [3:0]  size;
    upt_parity_t parity;
    upt_stop_t   stop;
  } upt_line_cfg_t;
endpackage

/* File: hdl/upt_trigger.sv */
// Operation
// - after polarity, idle level decodes as one, start bit as zero.
// - idle polarity selects low-is-one or high-is-one, default high, both lines.
// - data polarity setting is an alias of idle polarity, default high-active.
// - data bits per symbol 5 to 9, default 8.
// - parity odd, even or none, default none.
// - stop bits one, one and a half or two, default one.
// - bit rate 100 to 78.1E6 bits per second, default 115200.
// - gap at least the burst idle time starts a new burst.
// - transmit line optional, disabled by default, receive only then.
// - transmit use on instance 1 or 3 raises lane_pair_busy for the neighbour instance.
// - trigger evaluates one selectable line, receive or transmit.
// - burst mode fires on first start bit after a long idle.
// - start-bit mode, default, fires on every start bit.
// - indexed mode fires on the n-th symbol of a burst.
// - symbol mode fires on any symbol matching the pattern.
// - pattern mode matches symbols at an offset in the burst.
// - parity mode fires on parity mismatch; framing mode on stop error.
// - break mode fires when all-zero data is followed by stop bits that stay low.
// - pattern up to 32 bits of 0, 1 or don't-care, default 00000001.
// - pattern length one to four symbols, default one.
// - pattern skip count 0 to 4095, default zero.
// - break means line low longer than a symbol after start bit.
`timescale 1ns/10ps
`include "upt_cfg.svh"

module upt_decoder (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   enable,
  input  wire logic                   line,
  input  wire upt_pkg::upt_line_cfg_t cfg,
  input  wire logic [27:0]            baud,
  input  wire logic [31:0]            idle_cycles,
  output logic                        start_pulse,
  output logic                        burst_pulse,
  output logic                        sym_valid,
  output upt_pkg::upt_sym_t           sym,
  output logic [11:0]                 sym_index,
  output logic                        brk_pulse
);
  upt_pkg::upt_dec_state_t state;
  logic [27:0] acc;
  logic [28:0] acc_sum;
  logic        tick;
  logic        half_tick;
  logic [3:0]  bit_cnt;
  logic [8:0]  shreg;
  logic        par_err;
  logic [31:0] idle_cnt;
  logic [1:0]  brk_wait;
  logic        stop2_due;

  assign acc_sum   = {1'b0, acc} + {1'b0, baud};
  assign tick      = acc_sum >= {1'b0, `UPT_CLK_HZ};
  assign half_tick = (acc < `UPT_HALF_HZ) && (acc_sum >= {1'b0, `UPT_HALF_HZ});
  assign stop2_due = (cfg.stop == upt_pkg::STOP_ONE_HALF) ? half_tick : tick;

  // phase accumulator parked at half a bit while idle so ticks land mid-bit
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc <= `UPT_HALF_HZ;
    end else if (state == upt_pkg::ST_IDLE) begin
      acc <= `UPT_HALF_HZ;
    end else if (tick) begin
      acc <= acc_sum[27:0] - `UPT_CLK_HZ;
    end else begin
      acc <= acc_sum[27:0];
    end
  end

  // saturates so the first start after reset opens a burst
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idle_cnt <= 32'hffffffff;
    end else if (state != upt_pkg::ST_IDLE) begin
      idle_cnt <= 32'h00000000;
    end else if (line && idle_cnt != 32'hffffffff) begin
      idle_cnt <= idle_cnt + 32'h00000001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state       <= upt_pkg::ST_IDLE;
      start_pulse <= 1'b0;
      burst_pulse <= 1'b0;
      sym_valid   <= 1'b0;
      brk_pulse   <= 1'b0;
      sym         <= '0;
      sym_index   <= 12'h000;
      bit_cnt     <= 4'h0;
      shreg       <= 9'h000;
      par_err     <= 1'b0;
      brk_wait    <= 2'h0;
    end else begin
      start_pulse <= 1'b0;
      burst_pulse <= 1'b0;
      sym_valid   <= 1'b0;
      brk_pulse   <= 1'b0;
      case (state)
        upt_pkg::ST_IDLE: begin
          if (enable && !line) begin
            state       <= upt_pkg::ST_START;
            start_pulse <= 1'b1;
            par_err     <= 1'b0;
            if (idle_cnt >= idle_cycles) begin
              burst_pulse <= 1'b1;
              sym_index   <= 12'h000;
            end else if (sym_index != 12'hfff) begin
              sym_index <= sym_index + 12'h001;
            end
          end
        end
        upt_pkg::ST_START: begin
          if (tick) begin
            if (line) begin
              sym_valid <= 1'b1;
              sym       <= '{data: 9'h000, flags: '{1'b1, 1'b0, 1'b0, 1'b0}};
              state     <= upt_pkg::ST_IDLE;
            end else begin
              bit_cnt <= 4'h0;
              shreg   <= 9'h000;
              state   <= upt_pkg::ST_DATA;
            end
          end
        end
        upt_pkg::ST_DATA: begin
          if (tick) begin
            shreg[bit_cnt] <= line;
            bit_cnt        <= bit_cnt + 4'h1;
            if (bit_cnt == cfg.size - 4'h1) begin
              state <= (cfg.parity == upt_pkg::PAR_ODD || cfg.parity == upt_pkg::PAR_EVEN) ?
                       upt_pkg::ST_PARITY : upt_pkg::ST_STOP1;
            end
          end
        end
        upt_pkg::ST_PARITY: begin
          if (tick) begin
            par_err <= ((^shreg) ^ line) != (cfg.parity == upt_pkg::PAR_ODD);
            state   <= upt_pkg::ST_STOP1;
          end
        end
        upt_pkg::ST_STOP1, upt_pkg::ST_STOP2: begin
          if ((state == upt_pkg::ST_STOP1) ? tick : stop2_due) begin
            if (line && state == upt_pkg::ST_STOP1 && cfg.stop != upt_pkg::STOP_ONE) begin
              state <= upt_pkg::ST_STOP2;
            end else begin
              sym_valid <= 1'b1;
              sym       <= '{data: shreg, flags: '{1'b0, !line, par_err, 1'b0}};
              state     <= line ? upt_pkg::ST_IDLE : upt_pkg::ST_WAITHI;
              brk_wait  <= (!line && shreg == 9'h000) ? `UPT_BRK_BITS : 2'h0;
            end
          end
        end
        upt_pkg::ST_WAITHI: begin
          // a stop error keeps decoding parked until the line returns to idle
          if (line) begin
            state <= upt_pkg::ST_IDLE;
          end else if (tick && brk_wait != 2'h0) begin
            brk_wait <= brk_wait - 2'h1;
            if (brk_wait == 2'h1) begin
              brk_pulse <= 1'b1;
              sym_valid <= 1'b1;
              sym       <= '{data: 9'h000, flags: '{1'b0, 1'b1, 1'b0, 1'b1}};
            end
          end
        end
        default: state <= upt_pkg::ST_IDLE;
      endcase
    end
  end

  chk_start_catch: assert property (@(posedge ref_clk) disable iff (rst)
    state == upt_pkg::ST_IDLE && enable && !line |=> state == upt_pkg::ST_START && start_pulse)
    else $error("start edge not taken");
  chk_break_low: assert property (@(posedge ref_clk) disable iff (rst)
    brk_pulse |-> $past(!line) && sym.flags.brk && state == upt_pkg::ST_WAITHI)
    else $error("break flagged on a high line");
endmodule

module upt_trigger #(
  parameter int unsigned BUS_INDEX = 1
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        rx_in,
  input  wire logic        tx_in,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             trig_out,
  output logic             sym_valid,
  output upt_pkg::upt_sym_t sym,
  output logic             lane_pair_busy
);
  logic [2:0]             rx_sync;
  logic [2:0]             tx_sync;
  logic                   rx_lvl;
  logic                   tx_lvl;
  logic                   pol_low;
  upt_pkg::upt_line_cfg_t line_cfg;
  logic                   tx_en;
  logic                   src_tx;
  logic [27:0]            baud;
  logic [31:0]            idle_cycles;
  upt_pkg::upt_mode_t     mode;
  logic [1:0]             plen;
  logic [11:0]            skip;
  logic [11:0]            nth;
  logic [31:0]            pat_val;
  logic [31:0]            pat_care;
  logic [15:0]            trig_cnt;
  logic                   pat_run;
  logic                   d_start [2];
  logic                   d_burst [2];
  logic                   d_valid [2];
  upt_pkg::upt_sym_t      d_sym [2];
  logic [11:0]            d_index [2];
  logic                   d_brk [2];
  logic                   sel;
  logic                   s_ok;
  logic [11:0]            pat_k;
  logic                   in_win;
  logic                   pat_m;
  logic                   fire;

  function automatic logic sym_match(input logic [8:0] d, input logic [8:0] v, input logic [8:0] c);
    sym_match = ((d ^ v) & c) == 9'h000;
  endfunction

  function automatic logic [3:0] clamp_size(input logic [3:0] s);
    clamp_size = (s < `UPT_SIZE_MIN) ? `UPT_SIZE_MIN : (s > `UPT_SIZE_MAX) ? `UPT_SIZE_MAX : s;
  endfunction

  // change accepted once the second and third stages agree
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_sync <= 3'h7;
      tx_sync <= 3'h7;
      rx_lvl  <= 1'b1;
      tx_lvl  <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], rx_in};
      tx_sync <= {tx_sync[1:0], tx_in};
      if (rx_sync[1] == rx_sync[2]) begin
        rx_lvl <= rx_sync[2];
      end
      if (tx_sync[1] == tx_sync[2]) begin
        tx_lvl <= tx_sync[2];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pol_low     <= 1'b0;
      line_cfg    <= '{`UPT_SIZE_RST, upt_pkg::PAR_NONE, upt_pkg::STOP_ONE};
      tx_en       <= 1'b0;
      src_tx      <= 1'b0;
      baud        <= `UPT_BAUD_RST;
      idle_cycles <= `UPT_IDLE_RST;
      mode        <= upt_pkg::MODE_START;
      plen        <= 2'h0;
      skip        <= 12'h000;
      nth         <= `UPT_NTH_RST;
      pat_val     <= `UPT_PATV_RST;
      pat_care    <= `UPT_PATC_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `UPT_A_LINE: begin
          pol_low         <= reg_wdata[`UPT_F_POL];
          line_cfg.size   <= clamp_size(reg_wdata[`UPT_F_SIZE]);
          line_cfg.parity <= upt_pkg::upt_parity_t'(reg_wdata[`UPT_F_PAR]);
          line_cfg.stop   <= upt_pkg::upt_stop_t'(reg_wdata[`UPT_F_STOP]);
          tx_en           <= reg_wdata[`UPT_F_TXEN];
          src_tx          <= reg_wdata[`UPT_F_SRC];
        end
        `UPT_A_DPOL: pol_low <= reg_wdata[`UPT_F_POL];
        `UPT_A_BAUD: begin
          if (reg_wdata[27:0] < `UPT_BAUD_MIN || reg_wdata[31:28] != 4'h0) begin
            baud <= (reg_wdata[31:28] != 4'h0) ? `UPT_BAUD_MAX : `UPT_BAUD_MIN;
          end else begin
            baud <= (reg_wdata[27:0] > `UPT_BAUD_MAX) ? `UPT_BAUD_MAX : reg_wdata[27:0];
          end
        end
        `UPT_A_IDLE: idle_cycles <= reg_wdata;
        `UPT_A_TRIG: begin
          mode <= upt_pkg::upt_mode_t'(reg_wdata[`UPT_F_MODE]);
          plen <= reg_wdata[`UPT_F_PLEN];
          skip <= reg_wdata[`UPT_F_SKIP];
        end
        `UPT_A_NTH:  nth <= reg_wdata[`UPT_F_NTH];
        `UPT_A_PATV: pat_val <= reg_wdata;
        `UPT_A_PATC: pat_care <= reg_wdata;
        default: ;
      endcase
    end
  end

  // one decoder per line; the transmit one idles while the line is unused
  upt_decoder u_rx (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .enable      (1'b1),
    .line        (rx_lvl ^ pol_low),
    .cfg         (line_cfg),
    .baud        (baud),
    .idle_cycles (idle_cycles),
    .start_pulse (d_start[0]),
    .burst_pulse (d_burst[0]),
    .sym_valid   (d_valid[0]),
    .sym         (d_sym[0]),
    .sym_index   (d_index[0]),
    .brk_pulse   (d_brk[0])
  );
  upt_decoder u_tx (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .enable      (tx_en),
    .line        (tx_lvl ^ pol_low),
    .cfg         (line_cfg),
    .baud        (baud),
    .idle_cycles (idle_cycles),
    .start_pulse (d_start[1]),
    .burst_pulse (d_burst[1]),
    .sym_valid   (d_valid[1]),
    .sym         (d_sym[1]),
    .sym_index   (d_index[1]),
    .brk_pulse   (d_brk[1])
  );

  assign sel    = tx_en && src_tx;
  assign s_ok   = d_valid[sel] && !d_sym[sel].flags.start_err && !d_sym[sel].flags.brk;
  assign pat_k  = d_index[sel] - skip;
  assign in_win = d_index[sel] >= skip && pat_k <= {10'h000, plen};
  assign pat_m  = sym_match({1'b0, d_sym[sel].data[7:0]}, {1'b0, pat_val[{pat_k[1:0], 3'b000} +: 8]},
                            {1'b0, pat_care[{pat_k[1:0], 3'b000} +: 8]});

  always_comb begin
    case (mode)
      upt_pkg::MODE_BURST:   fire = d_burst[sel];
      upt_pkg::MODE_START:   fire = d_start[sel];
      upt_pkg::MODE_INDEXED: fire = s_ok && d_index[sel] == nth - 12'h001;
      upt_pkg::MODE_SYMBOL:  fire = s_ok && sym_match(d_sym[sel].data, pat_val[8:0], pat_care[8:0]);
      upt_pkg::MODE_PATTERN: fire = s_ok && in_win && pat_k[1:0] == plen && pat_m &&
                                    (pat_k[1:0] == 2'h0 || pat_run);
      upt_pkg::MODE_PARITY:  fire = d_valid[sel] && d_sym[sel].flags.parity_err;
      upt_pkg::MODE_FRAMING: fire = s_ok && d_sym[sel].flags.stop_err;
      upt_pkg::MODE_BREAK:   fire = d_brk[sel];
      default:               fire = 1'b0;
    endcase
  end

  // running match over the leading symbols of the pattern window
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pat_run <= 1'b0;
    end else if (s_ok && in_win) begin
      pat_run <= (pat_k[1:0] == 2'h0) ? pat_m : (pat_run && pat_m);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trig_out       <= 1'b0;
      sym_valid      <= 1'b0;
      sym            <= '0;
      lane_pair_busy <= 1'b0;
      trig_cnt       <= 16'h0000;
    end else begin
      trig_out       <= fire;
      sym_valid      <= d_valid[sel];
      sym            <= d_valid[sel] ? d_sym[sel] : sym;
      lane_pair_busy <= tx_en && (BUS_INDEX == 1 || BUS_INDEX == 3);
      if (fire) begin
        trig_cnt <= trig_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `UPT_A_LINE: reg_rdata <= {21'h000000, src_tx, tx_en, line_cfg.stop, line_cfg.parity,
                                   line_cfg.size, pol_low};
        `UPT_A_DPOL: reg_rdata <= {31'h00000000, pol_low};
        `UPT_A_BAUD: reg_rdata <= {4'h0, baud};
        `UPT_A_IDLE: reg_rdata <= idle_cycles;
        `UPT_A_TRIG: reg_rdata <= {4'h0, skip, 10'h000, plen, 1'b0, mode};
        `UPT_A_NTH:  reg_rdata <= {20'h00000, nth};
        `UPT_A_PATV: reg_rdata <= pat_val;
        `UPT_A_PATC: reg_rdata <= pat_care;
        `UPT_A_STAT: reg_rdata <= {trig_cnt, 2'h0, lane_pair_busy, sym.flags, sym.data};
        default:     reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  chk_start_fire: assert property (@(posedge ref_clk) disable iff (rst)
    mode == upt_pkg::MODE_START && d_start[sel] |=> trig_out)
    else $error("start bit did not fire");
  chk_burst_fire: assert property (@(posedge ref_clk) disable iff (rst)
    mode == upt_pkg::MODE_BURST && !d_burst[sel] |=> !trig_out)
    else $error("burst trigger without burst start");
  chk_parity_fire: assert property (@(posedge ref_clk) disable iff (rst)
    mode == upt_pkg::MODE_PARITY && trig_out |-> sym_valid && sym.flags.parity_err)
    else $error("parity trigger without parity error");
  chk_break_fire: assert property (@(posedge ref_clk) disable iff (rst)
    mode == upt_pkg::MODE_BREAK && trig_out |-> sym.flags.brk && sym.flags.stop_err)
    else $error("break trigger without break symbol");
  chk_reset_cfg: assert property (@(posedge ref_clk) disable iff (rst)
    $past(rst) |-> line_cfg.size == `UPT_SIZE_RST && mode == upt_pkg::MODE_START && !tx_en)
    else $error("wrong defaults after reset");
  chk_lane_pair: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(tx_en) |=> lane_pair_busy == (BUS_INDEX == 1 || BUS_INDEX == 3))
    else $error("neighbour lane state wrong");
  chk_tx_silent: assert property (@(posedge ref_clk) disable iff (rst)
    !tx_en && !$past(tx_en) |-> !d_start[1])
    else $error("disabled transmit line decoded");
  chk_read_lat: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == `UPT_A_BAUD |=> reg_rdata == {4'h0, $past(baud)})
    else $error("bit rate readback wrong");
endmodule

/* File: tb/upt_line_model.sv */
`timescale 1ns/10ps
module upt_line_model #(
  parameter int BIT_CYC = 10
) (
  input  wire logic ref_clk,
  input  wire logic pol_low,
  output logic      line
);
  logic lvl;
  // polarity folded in at the pin so frames are built in logic levels
  assign line = lvl ^ pol_low;
  initial lvl = 1'b1;
  task automatic put(input logic b, input int n);
    lvl <= b;
    repeat (n) @(posedge ref_clk);
  endtask
  // stop length in half bits; a long low stop after all-zero data makes a break
  task automatic send(input logic [8:0] d, input int size, input int par, input int stop_half,
                      input logic bad_par, input logic stop_low, input int gap);
    logic p;
    p = ^d ^ (par == 1) ^ bad_par;
    put(1'b0, BIT_CYC);
    for (int i = 0; i < size; i++) put(d[i], BIT_CYC);
    if (par != 0) put(p, BIT_CYC);
    put(~stop_low, BIT_CYC * stop_half / 2);
    put(1'b1, gap);
  endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic              ref_clk;
  logic              rst;
  logic              rx_in;
  logic              tx_in;
  logic              pol_low;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [31:0]       reg_rdata;
  logic              trig_out;
  logic              sym_valid;
  upt_pkg::upt_sym_t sym;
  logic              lane_pair_busy;
  upt_pkg::upt_sym_t exp_q[$];
  int                miscompares = 0;
  int                check_count = 0;
  int                trig_seen = 0;
  int                trig_exp = 0;
  int                seed = 32'hef2a;
  int                sz = 8;
  int                pr = 0;
  logic [39:0]       dflt[8] = '{40'h00_00000010, 40'h08_0001c200, 40'h0c_00000364, 40'h10_00000001,
                                 40'h14_00000001, 40'h18_00000001, 40'h20_00000000, 40'h40_00000000};

  upt_trigger #(.BUS_INDEX(1)) upt_trigger_inst (.ref_clk(ref_clk), .rst(rst), .rx_in(rx_in),
    .tx_in(tx_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trig_out(trig_out), .sym_valid(sym_valid), .sym(sym),
    .lane_pair_busy(lane_pair_busy));
  upt_line_model upt_line_model_inst (.ref_clk(ref_clk), .pol_low(pol_low), .line(rx_in));
  upt_line_model upt_line_model_tx_inst (.ref_clk(ref_clk), .pol_low(pol_low), .line(tx_in));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // one idle edge so a following write never re-drives the strobe in this step
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    v = reg_rdata;
  endtask
  task automatic line_cfg(input int s, input int p, input int st, input int txe, input int src);
    sz = s;
    pr = p;
    wr(8'h00, (src << 10) | (txe << 9) | (st << 7) | (p << 5) | (s << 1));
  endtask
  // a break frame leaves a stop error symbol and then a break symbol
  task automatic xmit(input int tx, input logic [8:0] d, input int sh, input logic bad,
                      input logic slow, input int gap, input int nexp);
    logic [8:0] m;
    m = d & 9'((1 << sz) - 1);
    if (nexp > 0) exp_q.push_back({m, 1'b0, slow, bad, 1'b0});
    if (nexp > 1) exp_q.push_back({9'h000, 4'h5});
    if (tx != 0) upt_line_model_tx_inst.send(m, sz, pr, sh, bad, slow, gap);
    else upt_line_model_inst.send(m, sz, pr, sh, bad, slow, gap);
  endtask
  task automatic burst3(input logic [8:0] a, input logic [8:0] b, input logic [8:0] c);
    xmit(0, a, 2, 1'b0, 1'b0, 20, 1);
    xmit(0, b, 2, 1'b0, 1'b0, 20, 1);
    xmit(0, c, 2, 1'b0, 1'b0, 400, 1);
  endtask

  always @(posedge ref_clk) begin
    if (trig_out === 1'b1) trig_seen++;
    if (sym_valid === 1'b1) begin
      if (exp_q.size() == 0) check("extra symbol", 32'h1, 32'h0);
      else check("symbol", {19'h0, sym}, {19'h0, exp_q.pop_front()});
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    logic [31:0] v;
    rst       = 1'b1;
    pol_low   = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    foreach (dflt[i]) begin
      rd(dflt[i][39:32], v);
      check("reset value", v, dflt[i][31:0]);
    end
    check("lane busy off", {31'h0, lane_pair_busy}, 32'h0);
    wr(8'h08, 32'h00000032);
    rd(8'h08, v);
    check("rate floor", v, 32'h00000064);
    wr(8'h08, 32'h00989680);
    wr(8'h0c, 32'h0000012c);
    // random sizes and parities, stop lengths cycled one, one and a half, two, start mode
    for (int i = 0; i < 6; i++) begin
      line_cfg(5 + $unsigned($random(seed)) % 5, $unsigned($random(seed)) % 3, i % 3, 0, 0);
      xmit(0, 9'($random(seed)), 2 + i % 3, 1'b0, 1'b0, 20, 1);
    end
    trig_exp += 6;
    wr(8'h10, 32'h5);
    line_cfg(8, 2, 0, 0, 0);
    xmit(0, 9'h0a5, 2, 1'b1, 1'b0, 20, 1);
    line_cfg(8, 1, 0, 0, 0);
    xmit(0, 9'h0a5, 2, 1'b0, 1'b0, 20, 1);
    xmit(0, 9'h03c, 2, 1'b1, 1'b0, 400, 1);
    trig_exp += 2;
    check("start and parity triggers", trig_seen, trig_exp);
    line_cfg(8, 0, 0, 0, 0);
    wr(8'h10, 32'h0);
    burst3(9'h001, 9'h002, 9'h003);
    burst3(9'h004, 9'h005, 9'h006);
    trig_exp += 2;
    check("burst triggers", trig_seen, trig_exp);
    wr(8'h14, 32'h3);
    wr(8'h10, 32'h2);
    burst3(9'h011, 9'h022, 9'h033);
    trig_exp += 1;
    check("indexed trigger", trig_seen, trig_exp);
    wr(8'h18, 32'h55);
    wr(8'h10, 32'h3);
    burst3(9'h012, 9'h055, 9'h055);
    trig_exp += 2;
    check("symbol triggers", trig_seen, trig_exp);
    wr(8'h18, 32'h0000b2a1);
    wr(8'h1c, 32'h0000ffff);
    wr(8'h10, 32'h00010014);
    burst3(9'h011, 9'h0a1, 9'h0b2);
    burst3(9'h0a1, 9'h0b2, 9'h011);
    trig_exp += 1;
    check("pattern trigger", trig_seen, trig_exp);
    wr(8'h10, 32'h6);
    xmit(0, 9'h03c, 2, 1'b0, 1'b1, 400, 1);
    wr(8'h10, 32'h7);
    xmit(0, 9'h000, 8, 1'b0, 1'b1, 400, 2);
    trig_exp += 2;
    check("framing and break", trig_seen, trig_exp);
    wr(8'h10, 32'h1);
    pol_low <= 1'b1;
    // setting lands with the synchronised pin, else the flip reads as a start bit
    repeat (3) @(posedge ref_clk);
    wr(8'h04, 32'h1);
    rd(8'h04, v);
    check("data polarity", v, 32'h1);
    xmit(0, 9'h096, 2, 1'b0, 1'b0, 400, 1);
    pol_low <= 1'b0;
    repeat (3) @(posedge ref_clk);
    line_cfg(8, 0, 0, 1, 1);
    @(posedge ref_clk);
    check("lane busy on", {31'h0, lane_pair_busy}, 32'h1);
    xmit(1, 9'h05a, 2, 1'b0, 1'b0, 400, 1);
    xmit(0, 9'h077, 2, 1'b0, 1'b0, 400, 0);
    trig_exp += 2;
    check("polarity and source", trig_seen, trig_exp);
    rd(8'h20, v);
    check("trigger count", v[31:16], 32'(trig_exp));
    check("pending symbols", exp_q.size(), 32'h0);
    wrap_up();
  end
endmodule
